// >>> hw/sws_pkg.sv
package sws_pkg;

  // Clock period and the fixed interval tick of 0.01 ms.
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS       = 10000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int MAX_FREQ_HZ   = 10000;
  // Phase step per cycle for one hertz of a 32-bit accumulator.
  localparam longint CLK_HZ    = 64'd1000000000 / 64'(CLK_PERIOD_NS);
  localparam logic [31:0] PHASE_K = 32'((64'd1 << 32) / CLK_HZ);

  // Register byte offsets.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CFG    = 8'h04;
  localparam logic [7:0] A_AMP    = 8'h08;
  localparam logic [7:0] A_OFFS   = 8'h0c;
  localparam logic [7:0] A_FREQ   = 8'h10;
  localparam logic [7:0] A_FIRST  = 8'h14;
  localparam logic [7:0] A_SECOND = 8'h18;
  localparam logic [7:0] A_STAT_V = 8'h1c;
  localparam logic [7:0] A_STAT_I = 8'h20;
  localparam logic [7:0] A_STAT_P = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;

  // Command bits of the control register.
  localparam int CTRL_LOAD  = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_STOP  = 2;
  localparam int CTRL_ONOFF = 3;
  localparam int CTRL_CLR   = 4;
  // Configuration fields.
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_TARGET   = 2;

  // Reset values: one tick and one hertz are the smallest legal settings.
  localparam logic [31:0] RST_T    = 32'h0000_0001;
  localparam logic [13:0] RST_FREQ = 14'h0001;

  typedef enum logic [1:0] {
    FN_NONE = 2'b00,
    FN_SINE = 2'b01,
    FN_TRI  = 2'b10,
    FN_RECT = 2'b11
  } sws_func_e;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_LOAD  = 2'b01,
    S_READY = 2'b10,
    S_RUN   = 2'b11
  } sws_state_e;

  // Quarter sine in Q15, index k gives sin(k * pi / 32).
  localparam logic [15:0] SIN_Q [0:16] = '{
    16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb, 16'h3c56,
    16'h471c, 16'h5133, 16'h5a82, 16'h62f2, 16'h6a6d, 16'h70e2,
    16'h7641, 16'h7a7c, 16'h7d89, 16'h7f61, 16'h7fff};

endpackage

// >>> hw/sws_top.sv
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
// How it works
// - Load sets static values, input on, start.
// - Start refused until load finished.
// - Static values drive outputs outside a run.
// - Current waveform starts from zero amperes.
// - Start or off-state press starts at once.
// - Stop halts waveform, input stays on.
// - Press while running halts and switches off.
// - Any alarm aborts, switches off, reports.
// - Sine offset between amplitude and nominal minus amplitude.
// - Sine equals offset plus amplitude times sine.
// - Sine frequency fixed, up to 10000 Hz.
// - Triangle ramps up first interval, down second.
// - Triangle intervals independent, period is their sum.
// - Triangle offset is foot, peak within nominal.
// - Rectangle holds high for pulse, low for pause.
// - Rectangle period is pulse plus pause.
// - Rectangle offset is low level, within nominal.
// - Waveform drives one value, others stay limits.
// - Configuration changes only while input is off.
// - Generator unavailable in resistance adjust mode.
module sws_top #(
  parameter logic [15:0] NOMINAL = 16'hffff // Rated value of the set-value scale.
) (
  input  wire logic        hclk,                   // System clock, 50 MHz.
  input  wire logic        hresetn,                // Asynchronous reset, active low.
  input  wire logic        hsel,                   // Slave select.
  input  wire logic [31:0] haddr,                  // Byte address.
  input  wire logic [1:0]  htrans,                 // Transfer type.
  input  wire logic        hwrite,                 // Write when high.
  input  wire logic [2:0]  hsize,                  // Transfer size, word only.
  input  wire logic [31:0] hwdata,                 // Write data.
  input  wire logic        hready,                 // Bus ready.
  output logic      [31:0] hrdata,                 // Read data.
  output logic             hreadyout,              // Slave ready.
  output logic             hresp,                  // Always OKAY.
  input  wire logic        device_alarm,           // Any device alarm pin.
  input  wire logic        overpower_protection,   // Power protection trip.
  input  wire logic        overcurrent_protection, // Current protection trip.
  input  wire logic        event_alarm,            // Event with alarm action.
  input  wire logic        resistance_adjust_mode, // Resistance mode active.
  output logic      [15:0] set_voltage,            // Voltage set value.
  output logic      [15:0] set_current,            // Current set value.
  output logic      [15:0] set_power,              // Power set value.
  output logic             input_enable,           // DC input switched on.
  output logic             alarm_report            // Sticky alarm report.
);

  localparam int DIV_W = $clog2(sws_pkg::TICK_CYC);

  // A zero rating leaves no legal amplitude or offset.
  if (NOMINAL == 16'h0000)
  begin : g_chk
    $error("NOMINAL must be nonzero.");
  end

  // Pin inputs pass two flops; only the second stage is read.
  logic [4:0] pin_meta; // First synchroniser stage.
  logic [4:0] pin_sync; // Second synchroniser stage.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end
    else
    begin
      pin_meta <= {resistance_adjust_mode, event_alarm, overcurrent_protection,
                   overpower_protection, device_alarm};
      pin_sync <= pin_meta;
    end
  end

  logic any_alarm; // Any trip that must abort a run.
  logic res_mode;  // Resistance adjust mode, synchronised.
  assign any_alarm = |pin_sync[3:0];
  assign res_mode  = pin_sync[4];

  // Bus slave: zero wait states, so the address phase is always taken.
  logic       acc;     // Valid address phase.
  logic       wr_pend; // Write data phase in progress.
  logic [7:0] wr_addr; // Latched write offset.
  assign acc = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend   <= acc && hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc)
      begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Register state.
  sws_pkg::sws_state_e state; // Sequencer state.
  sws_pkg::sws_func_e  func;  // Selected function.
  logic        target_i;      // Waveform on current when high.
  logic [15:0] amp;           // Amplitude.
  logic [15:0] offs;          // Offset.
  logic [13:0] freq;          // Sine frequency in hertz.
  logic [31:0] first_interval_time;  // Rise or pulse interval in ticks.
  logic [31:0] second_interval_time; // Fall or pause interval in ticks.
  logic [15:0] stat_v;        // Static voltage.
  logic [15:0] stat_i;        // Current limit for a voltage waveform.
  logic [15:0] stat_p;        // Static power.
  logic        param_err;     // Sticky refused-load flag.

  // Commands are one-cycle strobes from the control register.
  logic cmd_load, cmd_start, cmd_stop, cmd_onoff, cmd_clr;
  logic ctrl_wr; // Write to the control register.
  logic cfg_lock; // Configuration frozen.
  logic cfg_wr;   // Accepted write to a configuration register.
  assign ctrl_wr   = wr_pend && (wr_addr == sws_pkg::A_CTRL);
  assign cmd_load  = ctrl_wr && hwdata[sws_pkg::CTRL_LOAD];
  assign cmd_start = ctrl_wr && hwdata[sws_pkg::CTRL_START];
  assign cmd_stop  = ctrl_wr && hwdata[sws_pkg::CTRL_STOP];
  assign cmd_onoff = ctrl_wr && hwdata[sws_pkg::CTRL_ONOFF];
  assign cmd_clr   = ctrl_wr && hwdata[sws_pkg::CTRL_CLR];
  assign cfg_lock  = input_enable || (state == sws_pkg::S_RUN);
  assign cfg_wr    = wr_pend && !ctrl_wr && !cfg_lock
                     && (wr_addr != sws_pkg::A_STATUS);

  // Configuration registers; writes while the input is on are dropped.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      func     <= sws_pkg::FN_NONE;
      target_i <= 1'b0;
      amp      <= 16'h0000;
      offs     <= 16'h0000;
      freq     <= sws_pkg::RST_FREQ;
      first_interval_time  <= sws_pkg::RST_T;
      second_interval_time <= sws_pkg::RST_T;
      stat_v   <= 16'h0000;
      stat_i   <= 16'h0000;
      stat_p   <= 16'h0000;
    end
    else if (cfg_wr)
    begin
      case (wr_addr)
        sws_pkg::A_CFG:
        begin
          func     <= sws_pkg::sws_func_e'(hwdata[sws_pkg::CFG_FUNC_LSB +: 2]);
          target_i <= hwdata[sws_pkg::CFG_TARGET];
        end
        sws_pkg::A_AMP:    amp    <= hwdata[15:0];
        sws_pkg::A_OFFS:   offs   <= hwdata[15:0];
        sws_pkg::A_FREQ:   freq   <= hwdata[13:0];
        sws_pkg::A_FIRST:  first_interval_time  <= hwdata;
        sws_pkg::A_SECOND: second_interval_time <= hwdata;
        sws_pkg::A_STAT_V: stat_v <= hwdata[15:0];
        sws_pkg::A_STAT_I: stat_i <= hwdata[15:0];
        sws_pkg::A_STAT_P: stat_p <= hwdata[15:0];
        default:           stat_p <= stat_p;
      endcase
    end
  end

  // Settings check at load time; a bad set refuses the load.
  logic [16:0] peak;   // Offset plus amplitude.
  logic        cfg_ok; // Settings legal for the selected function.
  assign peak = {1'b0, offs} + {1'b0, amp};
  always_comb
  begin
    cfg_ok = !res_mode && (func != sws_pkg::FN_NONE)
             && (first_interval_time != 32'h0) && (second_interval_time != 32'h0)
             && (peak <= {1'b0, NOMINAL});
    if (func == sws_pkg::FN_SINE)
    begin
      // Offset no below amplitude, frequency in range.
      cfg_ok = cfg_ok && (offs >= amp) && (freq != 14'h0)
               && (freq <= 14'(sws_pkg::MAX_FREQ_HZ));
    end
  end

  // Sequencer: alarms first, then resistance mode, then commands.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state        <= sws_pkg::S_IDLE;
      input_enable <= 1'b0;
      param_err    <= 1'b0;
      alarm_report <= 1'b0;
    end
    else
    begin
      // Set wins over the clear for both sticky flags.
      if (cmd_clr)
      begin
        param_err    <= 1'b0;
        alarm_report <= 1'b0;
      end
      if (any_alarm)
      begin
        alarm_report <= 1'b1;
        input_enable <= 1'b0;
        state        <= sws_pkg::S_IDLE;
      end
      else if (res_mode)
      begin
        state <= sws_pkg::S_IDLE;
        if (cmd_load || cmd_start)
        begin
          param_err <= 1'b1;
        end
      end
      else if (cfg_wr)
      begin
        // New settings must be loaded again before a start.
        state <= sws_pkg::S_IDLE;
      end
      else
      begin
        unique case (state)
          sws_pkg::S_IDLE:
          begin
            if (cmd_load && cfg_ok && !input_enable)
            begin
              state <= sws_pkg::S_LOAD;
            end
            else if (cmd_load)
            begin
              param_err <= 1'b1;
            end
            else if (cmd_onoff)
            begin
              // Plain switch with nothing loaded; start stays refused.
              input_enable <= !input_enable;
            end
          end
          sws_pkg::S_LOAD:
          begin
            // Static values are out; now switch on and enable start.
            input_enable <= 1'b1;
            state        <= sws_pkg::S_READY;
          end
          sws_pkg::S_READY:
          begin
            if (cmd_start)
            begin
              input_enable <= 1'b1;
              state        <= sws_pkg::S_RUN;
            end
            else if (cmd_onoff && !input_enable)
            begin
              input_enable <= 1'b1;
              state        <= sws_pkg::S_RUN;
            end
            else if (cmd_onoff)
            begin
              input_enable <= 1'b0;
            end
            else if (cmd_load && !input_enable)
            begin
              state <= sws_pkg::S_LOAD;
            end
          end
          sws_pkg::S_RUN:
          begin
            if (cmd_onoff)
            begin
              input_enable <= 1'b0;
              state        <= sws_pkg::S_READY;
            end
            else if (cmd_stop)
            begin
              state <= sws_pkg::S_READY;
            end
          end
        endcase
      end
    end
  end

  // Tick divider and segment counter, cleared whenever not running.
  logic [DIV_W-1:0] div;     // Cycles within a tick.
  logic             tick;    // One-cycle 0.01 ms pulse.
  logic             seg;     // Second interval when high.
  logic [31:0]      seg_cnt; // Ticks elapsed in this interval.
  logic [31:0]      seg_len; // Length of this interval.
  logic [31:0]      phase;   // Sine phase accumulator.
  logic             run;     // Sequencer running.
  assign run     = (state == sws_pkg::S_RUN);
  assign tick    = run && (div == DIV_W'(sws_pkg::TICK_CYC - 1));
  assign seg_len = seg ? second_interval_time : first_interval_time;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div     <= '0;
      seg     <= 1'b0;
      seg_cnt <= 32'h0;
      phase   <= 32'h0;
    end
    else if (!run)
    begin
      div     <= '0;
      seg     <= 1'b0;
      seg_cnt <= 32'h0;
      phase   <= 32'h0;
    end
    else
    begin
      div   <= tick ? '0 : div + 1'b1;
      // Frequency is frozen for the run, so the step is constant.
      phase <= phase + 32'(freq * sws_pkg::PHASE_K);
      if (tick)
      begin
        if (seg_cnt + 32'h1 >= seg_len)
        begin
          seg     <= !seg;
          seg_cnt <= 32'h0;
        end
        else
        begin
          seg_cnt <= seg_cnt + 32'h1;
        end
      end
    end
  end

  // Waveform value.
  logic [3:0]         qi;     // Index within a quarter.
  logic [15:0]        qs;     // Quarter table value.
  logic signed [16:0] sin_v;  // Signed sine sample.
  logic signed [33:0] prod;   // Amplitude times sine.
  logic signed [17:0] sval;   // Sine result before clamp.
  logic [47:0]        num;    // Triangle ramp numerator.
  logic [47:0]        ramp;   // Triangle ramp above offset.
  logic [15:0]        wave;   // Selected waveform.
  always_comb
  begin
    qi = phase[29:26];
    qs = phase[30] ? sws_pkg::SIN_Q[5'd16 - {1'b0, qi}] : sws_pkg::SIN_Q[qi];
    sin_v = phase[31] ? -$signed({1'b0, qs}) : $signed({1'b0, qs});
    prod  = $signed({1'b0, amp}) * sin_v;
    sval  = $signed({2'b00, offs}) + 18'(prod >>> 15);
    // Rise over the first interval, fall over the second.
    num  = 48'(amp) * 48'(seg ? second_interval_time - seg_cnt : seg_cnt);
    ramp = num / 48'(seg_len);
    unique case (func)
      sws_pkg::FN_SINE: wave = sval[17] ? 16'h0000 : sval[15:0];
      sws_pkg::FN_TRI:  wave = offs + ramp[15:0];
      sws_pkg::FN_RECT: wave = seg ? offs : peak[15:0];
      sws_pkg::FN_NONE: wave = offs;
    endcase
  end

  // Set-value outputs: waveform on one quantity, the rest static.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      set_voltage <= 16'h0000;
      set_current <= 16'h0000;
      set_power   <= 16'h0000;
    end
    else
    begin
      set_power <= stat_p;
      if (target_i)
      begin
        set_voltage <= stat_v;
        // No static current exists, so outside a run it is zero.
        set_current <= run ? wave : 16'h0000;
      end
      else
      begin
        set_voltage <= run ? wave : stat_v;
        set_current <= stat_i;
      end
    end
  end

  // Read data is captured in the address phase.
  logic [31:0] rd_data; // Read multiplexer.
  always_comb
  begin
    case (haddr[7:0])
      sws_pkg::A_CFG:    rd_data = {29'h0, target_i, func};
      sws_pkg::A_AMP:    rd_data = {16'h0, amp};
      sws_pkg::A_OFFS:   rd_data = {16'h0, offs};
      sws_pkg::A_FREQ:   rd_data = {18'h0, freq};
      sws_pkg::A_FIRST:  rd_data = first_interval_time;
      sws_pkg::A_SECOND: rd_data = second_interval_time;
      sws_pkg::A_STAT_V: rd_data = {16'h0, stat_v};
      sws_pkg::A_STAT_I: rd_data = {16'h0, stat_i};
      sws_pkg::A_STAT_P: rd_data = {16'h0, stat_p};
      sws_pkg::A_STATUS: rd_data = {24'h0, res_mode, seg, cfg_ok, param_err,
                                    alarm_report, input_enable, state};
      default:           rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0;
    end
    else if (acc && !hwrite)
    begin
      hrdata <= rd_data;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_alarm_cuts_input: assert property (
    any_alarm |=> !input_enable && alarm_report && state == sws_pkg::S_IDLE)
    else $error("Alarm did not abort.");
  a_start_refused: assert property (
    state == sws_pkg::S_IDLE && cmd_start |=> state != sws_pkg::S_RUN)
    else $error("Start taken before load.");
  // An accepted settings write during the load step sends the sequencer back to idle.
  a_load_sequence: assert property (
    state == sws_pkg::S_LOAD && !any_alarm && !res_mode && !cfg_wr
    |=> state == sws_pkg::S_READY && input_enable)
    else $error("Load did not switch on.");
  a_load_valid: assert property (state == sws_pkg::S_LOAD |-> $past(cfg_ok))
    else $error("Illegal settings loaded.");
  a_current_zero: assert property (
    target_i && !run ##1 target_i |-> set_current == 16'h0000)
    else $error("Current not zero outside run.");
  a_static_volt: assert property (
    !target_i && !run ##1 !target_i |-> set_voltage == $past(stat_v))
    else $error("Static voltage missing.");
  a_stop_keeps: assert property (
    run && cmd_stop && !cmd_onoff && !any_alarm && !res_mode && !cfg_wr
    |=> state == sws_pkg::S_READY && input_enable)
    else $error("Stop changed input.");
  a_onoff_stops: assert property (
    run && cmd_onoff && !any_alarm && !res_mode && !cfg_wr
    |=> state == sws_pkg::S_READY && !input_enable)
    else $error("Press did not switch off.");
  a_start_on: assert property (
    state == sws_pkg::S_READY && cmd_start && !any_alarm && !res_mode && !cfg_wr
    |=> run && input_enable)
    else $error("Start did not run.");
  a_cfg_locked: assert property (
    wr_pend && wr_addr == sws_pkg::A_AMP && input_enable |=> $stable(amp))
    else $error("Config changed while on.");
  a_resmode_block: assert property (res_mode |=> !run)
    else $error("Ran in resistance mode.");
  a_rect_levels: assert property (
    run && func == sws_pkg::FN_RECT && !target_i ##1 run
    |-> set_voltage == ($past(seg) ? offs : peak[15:0]))
    else $error("Rectangle level wrong.");

  c_load_run: cover property (state == sws_pkg::S_LOAD ##1 state == sws_pkg::S_READY
    ##[1:50] run);
  c_rect_seg: cover property (run && func == sws_pkg::FN_RECT && tick && seg);
  c_alarm_run: cover property (run && any_alarm);

endmodule

// >>> tb/sws_panel_model.sv
`timescale 1ns/100ps
// Operator panel and power stage seen from the sequencer: fault pins and mode switch.
module sws_panel_model (
  input  wire logic       hclk,      // System clock.
  input  wire logic [4:0] fault_req, // Wanted pin levels, mode switch on top.
  output logic      [3:0] fault_pin, // Alarm, power, current and event pins.
  output logic            rmode      // Resistance adjust switch.
);
  // Pins move just after an edge, so the synchroniser sees a clean level.
  always @(posedge hclk)
  begin
    fault_pin <= fault_req[3:0];
    rmode     <= fault_req[4];
  end
endmodule

// >>> tb/tb_setpoint_waveform_sequencer.sv
`timescale 1ns/100ps
module tb_setpoint_waveform_sequencer;
  localparam logic [31:0] SV = 32'h0000_4000; // Static voltage.
  localparam logic [31:0] SI = 32'h0000_3000; // Static current limit.
  localparam logic [31:0] SP = 32'h0000_7000; // Static power limit.
  logic        hclk = 1'b0;    // Bus clock.
  logic        hresetn = 1'b0; // Reset, active low.
  logic        hsel = 1'b0;    // Select.
  logic [31:0] haddr = '0;     // Address.
  logic [1:0]  htrans = '0;    // Transfer type.
  logic        hwrite = 1'b0;  // Direction.
  logic [31:0] hwdata = '0;    // Write data.
  logic [31:0] hrdata;         // Read data.
  logic        hready;         // Slave ready fed back.
  logic [15:0] set_voltage;    // Set values.
  logic [15:0] set_current;
  logic [15:0] set_power;
  logic        input_enable;   // DC input.
  logic        hresp;          // Bus response.
  logic        alarm_report;   // Sticky alarm report.
  logic [4:0]  fault_req = '0; // Panel requests.
  logic [3:0]  fault_pin;      // Fault pins.
  logic        rmode;          // Mode switch.
  logic [31:0] rng = 32'h48008757; // Random state.
  logic [31:0] rd;             // Last read word.
  int          amp;            // Model amplitude.
  int          offs;           // Model offset.
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;

  always #10 hclk = ~hclk;

  sws_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .device_alarm(fault_pin[0]),
    .overpower_protection(fault_pin[1]), .overcurrent_protection(fault_pin[2]),
    .event_alarm(fault_pin[3]), .resistance_adjust_mode(rmode), .set_voltage(set_voltage),
    .set_current(set_current), .set_power(set_power), .input_enable(input_enable),
    .alarm_report(alarm_report));
  sws_panel_model panel (.hclk(hclk), .fault_req(fault_req), .fault_pin(fault_pin),
    .rmode(rmode));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic end_sim;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single word transfer; the address phase is held until ready is seen.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // A command strobe, then a few cycles so the registered outputs settle.
  task automatic cmd(input int b);
    xfer(1'b1, sws_pkg::A_CTRL, 32'h1 << b);
    repeat (3) @(posedge hclk);
  endtask

  task automatic stat(input logic [31:0] exp, input logic [31:0] mask);
    xfer(1'b0, sws_pkg::A_STATUS, '0);
    chk(rd & mask, exp);
  endtask

  task automatic setup(input logic [1:0] fn, input logic tgt, input int first_t,
                       input int second_t);
    xfer(1'b1, sws_pkg::A_CFG, {29'h0, tgt, fn});
    xfer(1'b1, sws_pkg::A_AMP, 32'(amp));
    xfer(1'b1, sws_pkg::A_OFFS, 32'(offs));
    xfer(1'b1, sws_pkg::A_FIRST, 32'(first_t));
    xfer(1'b1, sws_pkg::A_SECOND, 32'(second_t));
    xfer(1'b1, sws_pkg::A_STAT_V, SV);
    xfer(1'b1, sws_pkg::A_STAT_I, SI);
    xfer(1'b1, sws_pkg::A_STAT_P, SP);
  endtask

  // The whole run needs some seven thousand four hundred cycles; a hang is cut well after that.
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      $display("unexpected at %0t: run did not finish", $time);
      end_sim();
    end
  end

  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rng = xs(rng);
    amp = 100 + int'(rng[11:0]);
    offs = amp + int'(rng[23:12]);
    stat(32'h0, 32'hff);
    xfer(1'b0, 8'h3c, '0);
    chk(rd, '0);
    setup(2'd3, 1'b0, 2, 3);
    cmd(sws_pkg::CTRL_START);
    stat(32'h0, 32'h3);
    cmd(sws_pkg::CTRL_LOAD);
    stat(32'h6, 32'h7);
    chk(set_voltage, SV);
    chk(set_current, SI);
    cmd(sws_pkg::CTRL_START);
    repeat (497) @(posedge hclk);
    chk(set_voltage, 32'(offs + amp));
    repeat (1000) @(posedge hclk);
    chk(set_voltage, 32'(offs));
    repeat (1500) @(posedge hclk);
    chk(set_voltage, 32'(offs + amp));
    chk(set_power, SP);
    cmd(sws_pkg::CTRL_STOP);
    stat(32'h6, 32'h7);
    chk(set_voltage, SV);
    cmd(sws_pkg::CTRL_ONOFF);
    chk(input_enable, 1'b0);
    cmd(sws_pkg::CTRL_ONOFF);
    stat(32'h7, 32'h7);
    cmd(sws_pkg::CTRL_ONOFF);
    stat(32'h2, 32'h7);
    setup(2'd2, 1'b1, 4, 4);
    cmd(sws_pkg::CTRL_LOAD);
    chk(set_current, '0);
    cmd(sws_pkg::CTRL_START);
    repeat (1247) @(posedge hclk);
    chk(set_current, 32'(offs + amp * 2 / 4));
    repeat (2000) @(posedge hclk);
    chk(set_current, 32'(offs + amp * 2 / 4));
    chk(set_voltage, SV);
    xfer(1'b1, sws_pkg::A_AMP, 32'(amp + 1));
    chk(hresp, 1'b0);
    xfer(1'b0, sws_pkg::A_AMP, '0);
    chk(rd, 32'(amp));
    // Each fault source in turn aborts a running function.
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0)
      begin
        cmd(sws_pkg::CTRL_LOAD);
        cmd(sws_pkg::CTRL_START);
      end
      fault_req <= 5'h1 << i;
      repeat (6) @(posedge hclk);
      chk(input_enable, 1'b0);
      chk(alarm_report, 1'b1);
      stat(32'h8, 32'hf);
      fault_req <= '0;
      repeat (4) @(posedge hclk);
      cmd(sws_pkg::CTRL_CLR);
    end
    fault_req <= 5'h10;
    repeat (6) @(posedge hclk);
    cmd(sws_pkg::CTRL_LOAD);
    stat(32'h10, 32'h17);
    fault_req <= '0;
    repeat (4) @(posedge hclk);
    cmd(sws_pkg::CTRL_CLR);
    offs = amp - 1;
    setup(2'd1, 1'b0, 1, 1);
    cmd(sws_pkg::CTRL_LOAD);
    stat(32'h10, 32'h13);
    cmd(sws_pkg::CTRL_CLR);
    // A triangle whose peak would pass the rated value must be refused.
    xfer(1'b1, sws_pkg::A_CFG, 32'h0000_0002);
    xfer(1'b1, sws_pkg::A_OFFS, 32'h0000_ffff);
    cmd(sws_pkg::CTRL_LOAD);
    stat(32'h10, 32'h13);
    cmd(sws_pkg::CTRL_CLR);
    offs = amp + int'(rng[23:12]);
    setup(2'd1, 1'b0, 1, 1);
    xfer(1'b1, sws_pkg::A_FREQ, 32'd10000);
    cmd(sws_pkg::CTRL_LOAD);
    cmd(sws_pkg::CTRL_START);
    // The sine stays inside offset plus or minus amplitude; one step of rounding is allowed.
    for (int i = 0; i < 20; i++)
    begin
      repeat (37) @(posedge hclk);
      chk({31'h0, (set_voltage >= 16'(offs - amp)) && (set_voltage <= 16'(offs + amp + 1))},
        32'h1);
    end
    end_sim();
  end
endmodule
